// File: common/ctm_pkg.sv
// Constants and carrier types for the compact timer with PWM modes
// Behaviour
// - Compare mode, clear select 1: A match clears
// - Compare mode: pin changes only on A flag or timer start
// - Timer on rising edge restores initial pin level
// - Compare/timer mode, clear select 1: never set P flag
// - Mode bits 11 select timer/counter mode
// - Timer/counter mode like compare, pin undriven
// - Mode bits 10 select PWM mode
// - PWM mode ignores clear select bit
// - PWM: swap bit picks period and duty registers
// - PWM: set A and P flags on matches
// - PWM: active level and output function select
// - Invert bit inverts final PWM pin level
// - Swap 0: P code period, 128 counts per step, 0 is 1024
// - Duty at or above period gives full duty
// - Swap 1: A period, P code duty
// - Counting continues while output is forced
// - 10-bit counter, zero clear value wraps
// - Output function 00 inactive, 01 active, 10 PWM
// - Compare/timer mode, clear select 0: P match or overflow clears
package ctm_pkg;
    localparam int CTM_CNT_W    = 10;
    localparam int CTM_P_W      = 3;
    localparam int CTM_P_LSB    = 7;
    localparam logic [9:0] CTM_CNT_RST  = 10'h000;
    localparam logic [9:0] CTM_CNT_MAX  = 10'h3ff;
    localparam logic [1:0] CTM_MODE_CMP = 2'h0;
    localparam logic [1:0] CTM_MODE_PWM = 2'h2;
    localparam logic [1:0] CTM_MODE_TMR = 2'h3;
    localparam logic [1:0] CTM_FN_NONE  = 2'h0;
    localparam logic [1:0] CTM_FN_LOW   = 2'h1;
    localparam logic [1:0] CTM_FN_HIGH  = 2'h2;
    localparam logic [1:0] CTM_FN_TOG   = 2'h3;
    localparam logic [1:0] CTM_PF_INACT = 2'h0;
    localparam logic [1:0] CTM_PF_ACT   = 2'h1;
    localparam logic [1:0] CTM_PF_PWM   = 2'h2;

    typedef struct packed {
        logic       timer_on_bit;
        logic       mode_select_hi;
        logic       mode_select_lo;
        logic       output_function_hi;
        logic       output_function_lo;
        logic       output_control_bit;
        logic       output_invert_bit;
        logic       period_duty_swap;
        logic       counter_clear_select;
    } ctm_ctrl_t;

    typedef struct packed {
        logic       match_a_flag;
        logic       match_p_flag;
    } ctm_flags_t;
endpackage

// File: hw/ctm_sync.sv
// Two-stage synchroniser for control inputs arriving from outside
`timescale 1ns/10ps
module ctm_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    initial begin
        if (W < 1) begin
            $error("ctm_sync width must be at least one");
        end
    end

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // ctm_sync

// File: hw/ctm_timer.sv
// Compact 10-bit timer: compare match, timer/counter and PWM modes
`timescale 1ns/10ps
module ctm_timer
    import ctm_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        timer_tick,
    input  wire ctm_ctrl_t   ctrl,
    input  wire logic [9:0]  compare_a_value,
    input  wire logic [2:0]  compare_p_value,
    input  wire ctm_flags_t  flag_clear,
    output ctm_flags_t       flags,
    output logic [9:0]       count,
    output logic             match_a_pulse,
    output logic             match_p_pulse,
    output logic             pin_out,
    output logic             pin_oe
);
    typedef enum logic [1:0] {
        CTM_ST_CMP,
        CTM_ST_PWM,
        CTM_ST_TMR,
        CTM_ST_IDLE
    } ctm_mode_t;

    ctm_ctrl_t    ctrl_s;
    logic         tick_s;
    logic [9:0]   cnt_r;
    logic         on_d_r;
    logic         cmp_pin_r;
    logic         pwm_act_r;
    ctm_flags_t   flags_r;
    logic         pin_r;
    logic         oe_r;
    ctm_mode_t    mode;
    logic         on_rise;
    logic         a_eq;
    logic         p_eq;
    logic         a_zero;
    logic         p_zero;
    logic [2:0]   p_step;
    logic         ovf;
    logic         clr;
    logic         set_a;
    logic         set_p;
    logic         duty_hit;
    logic [10:0]  period_len;
    logic [10:0]  duty_len;
    logic         pwm_lvl;
    logic [1:0]   fn;

    // Control bits come from software in another domain; tick is a pin
    ctm_sync #(.W($bits(ctm_ctrl_t) + 1)) u_sync (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .d       ({ctrl, timer_tick}),
        .q       ({ctrl_s, tick_s})
    );

    // Period or duty length for a 3-bit code: 128 per step, 0 is 1024
    function automatic logic [10:0] code_len(input logic [2:0] c);
        code_len = (c == 3'h0) ? 11'h400 : {1'b0, c, 7'h00};
    endfunction

    always_comb begin
        case ({ctrl_s.mode_select_hi, ctrl_s.mode_select_lo})
            CTM_MODE_CMP: mode = CTM_ST_CMP;
            CTM_MODE_PWM: mode = CTM_ST_PWM;
            CTM_MODE_TMR: mode = CTM_ST_TMR;
            default:      mode = CTM_ST_IDLE;
        endcase
    end

    assign fn       = {ctrl_s.output_function_hi, ctrl_s.output_function_lo};
    assign on_rise  = ctrl_s.timer_on_bit && !on_d_r;
    assign a_zero   = (compare_a_value == 10'h000);
    assign p_zero   = (compare_p_value == 3'h0);
    assign a_eq     = !a_zero && (cnt_r == compare_a_value);
    // Code n hits on the last count of n steps; code 0 wraps onto 3ff
    assign p_step   = cnt_r[9:CTM_P_LSB] + 3'h1;
    assign p_eq     = (p_step == compare_p_value)
                      && (cnt_r[CTM_P_LSB-1:0] == 7'h7f);
    assign ovf      = (cnt_r == CTM_CNT_MAX);

    // A zero lets the counter run the full 1024 counts before clearing
    assign period_len = !ctrl_s.period_duty_swap ?
                        code_len(compare_p_value) :
                        a_zero ? 11'h400 :
                        {1'b0, compare_a_value};
    assign duty_len   = ctrl_s.period_duty_swap ?
                        code_len(compare_p_value) :
                        {1'b0, compare_a_value};

    always_comb begin
        clr   = 1'b0;
        set_a = 1'b0;
        set_p = 1'b0;
        if (tick_s && ctrl_s.timer_on_bit) begin
            case (mode)
                CTM_ST_PWM: begin
                    // Clear select ignored here
                    set_a = a_eq;
                    set_p = p_eq;
                    if (ctrl_s.period_duty_swap) begin
                        clr = a_eq || (a_zero && ovf);
                    end else begin
                        clr = p_eq || (p_zero && ovf);
                    end
                end
                CTM_ST_CMP, CTM_ST_TMR: begin
                    set_a = a_eq;
                    if (ctrl_s.counter_clear_select) begin
                        clr = a_eq || (a_zero && ovf);
                    end else begin
                        set_p = p_eq;
                        clr   = p_eq || (p_zero && ovf);
                    end
                end
                default: begin
                    clr = 1'b0;
                end
            endcase
        end
    end

    assign match_a_pulse = set_a;
    assign match_p_pulse = set_p;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            on_d_r <= 1'b0;
        end else begin
            on_d_r <= ctrl_s.timer_on_bit;
        end
    end

    // Counter: restart on timer on, runs in every mode incl. forced pin
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= CTM_CNT_RST;
        end else if (on_rise) begin
            cnt_r <= CTM_CNT_RST;
        end else if (clr) begin
            cnt_r <= CTM_CNT_RST;
        end else if (tick_s && ctrl_s.timer_on_bit) begin
            cnt_r <= cnt_r + 10'h001;
        end
    end

    // Sticky flags: a set in the clear cycle wins
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            flags_r <= '0;
        end else begin
            flags_r.match_a_flag <= set_a ||
                (flags_r.match_a_flag && !flag_clear.match_a_flag);
            flags_r.match_p_flag <= set_p ||
                (flags_r.match_p_flag && !flag_clear.match_p_flag);
        end
    end

    // Compare pin level, loaded on timer start, otherwise moved only by the A match flag event
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cmp_pin_r <= 1'b0;
        end else if (on_rise) begin
            cmp_pin_r <= ctrl_s.output_control_bit;
        end else if (mode == CTM_ST_CMP && set_a) begin
            case (fn)
                CTM_FN_LOW:  cmp_pin_r <= 1'b0;
                CTM_FN_HIGH: cmp_pin_r <= 1'b1;
                CTM_FN_TOG:  cmp_pin_r <= !cmp_pin_r;
                default:     cmp_pin_r <= cmp_pin_r;
            endcase
        end
    end

    // PWM phase: active from counter clear to duty match
    assign duty_hit = ({1'b0, cnt_r} + 11'h001 == duty_len);
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pwm_act_r <= 1'b0;
        end else if (on_rise) begin
            pwm_act_r <= (duty_len != 11'h000);
        end else if (tick_s && ctrl_s.timer_on_bit) begin
            if (clr) begin
                // Zero duty never reaches a match, so start inactive
                pwm_act_r <= (duty_len != 11'h000);
            end else if (duty_hit && duty_len < period_len) begin
                pwm_act_r <= 1'b0;
            end
        end
    end

    always_comb begin
        case (fn)
            CTM_PF_INACT: pwm_lvl = 1'b0;
            CTM_PF_ACT:   pwm_lvl = 1'b1;
            CTM_PF_PWM:   pwm_lvl = pwm_act_r;
            default:      pwm_lvl = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pin_r <= 1'b0;
            oe_r  <= 1'b0;
        end else begin
            case (mode)
                CTM_ST_CMP: begin
                    pin_r <= cmp_pin_r ^ ctrl_s.output_invert_bit;
                    oe_r  <= 1'b1;
                end
                CTM_ST_PWM: begin
                    // Active level then final inversion
                    pin_r <= (pwm_lvl ~^ ctrl_s.output_control_bit)
                             ^ ctrl_s.output_invert_bit;
                    oe_r  <= 1'b1;
                end
                default: begin
                    pin_r <= 1'b0;
                    oe_r  <= 1'b0;
                end
            endcase
        end
    end

    assign flags   = flags_r;
    assign count   = cnt_r;
    assign pin_out = pin_r;
    assign pin_oe  = oe_r;

    property p_no_p_flag;
        @(posedge clk_sys) disable iff (!rst_b)
        (mode != CTM_ST_PWM && ctrl_s.counter_clear_select) |-> !set_p;
    endproperty
    a_no_p_flag: assert property (p_no_p_flag)
        else $error("P flag set with clear select high");

    property p_clear_a;
        @(posedge clk_sys) disable iff (!rst_b)
        (mode == CTM_ST_CMP && ctrl_s.counter_clear_select && a_eq
         && tick_s && ctrl_s.timer_on_bit && !on_rise)
        |=> cnt_r == 10'h000;
    endproperty
    a_clear_a: assert property (p_clear_a)
        else $error("A match did not clear counter");

    property p_tmr_float;
        @(posedge clk_sys) disable iff (!rst_b)
        (mode == CTM_ST_TMR) |=> !pin_oe;
    endproperty
    a_tmr_float: assert property (p_tmr_float)
        else $error("Pin driven in timer mode");

    property p_on_init;
        @(posedge clk_sys) disable iff (!rst_b)
        on_rise |=> cmp_pin_r == $past(ctrl_s.output_control_bit);
    endproperty
    a_on_init: assert property (p_on_init)
        else $error("Pin not restored on timer start");

    property p_pin_only_a;
        @(posedge clk_sys) disable iff (!rst_b)
        (!on_rise && !(mode == CTM_ST_CMP && set_a)) |=> $stable(cmp_pin_r);
    endproperty
    a_pin_only_a: assert property (p_pin_only_a)
        else $error("Pin moved without A match");

    property p_pwm_flags;
        @(posedge clk_sys) disable iff (!rst_b)
        (mode == CTM_ST_PWM && a_eq && tick_s && ctrl_s.timer_on_bit)
        |=> flags.match_a_flag;
    endproperty
    a_pwm_flags: assert property (p_pwm_flags)
        else $error("PWM A flag missing");

    sequence s_pwm_on;
        mode == CTM_ST_PWM && fn == CTM_PF_ACT;
    endsequence
    property p_forced;
        @(posedge clk_sys) disable iff (!rst_b)
        s_pwm_on ##1 s_pwm_on |=> pin_out ==
            $past(ctrl_s.output_control_bit ^ ctrl_s.output_invert_bit);
    endproperty
    a_forced: assert property (p_forced)
        else $error("Forced active level wrong");

    property p_wrap;
        @(posedge clk_sys) disable iff (!rst_b)
        (ovf && tick_s && ctrl_s.timer_on_bit && !on_rise)
        |=> cnt_r == 10'h000;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("Counter did not wrap at max");
endmodule // ctm_timer

// File: verification/ctm_timer_tb.sv
// Self-checking bench for the compact timer, driven from its own ports
`timescale 1ns/10ps
module testbench
    import ctm_pkg::*;
;
    logic       clk_sys, rst_b, timer_tick;
    ctm_ctrl_t  ctrl;
    logic [9:0] compare_a_value, count, m_max;
    logic [2:0] compare_p_value;
    ctm_flags_t flag_clear, flags;
    logic       match_a_pulse, match_p_pulse, pin_out, pin_oe;
    int         errors, checks_done, cycles;
    int         m_len, m_hi, m_pa, m_pp, m_tog;
    int t_p[8]   = '{1, 1, 1, 3, 1, 1, 1, 0};
    int t_oc[8]  = '{1, 1, 0, 1, 1, 1, 1, 1};
    int t_inv[8] = '{0, 1, 0, 0, 0, 0, 0, 0};
    int t_fn[8]  = '{2, 2, 2, 2, 2, 0, 1, 2};
    int t_a[8]   = '{32, 32, 32, 100, 200, 32, 32, 512};
    int t_hi[8]  = '{32, 96, 96, 100, 128, 0, 128, 512};

    ctm_timer u_ctm_timer (.clk_sys(clk_sys), .rst_b(rst_b),
        .timer_tick(timer_tick), .ctrl(ctrl),
        .compare_a_value(compare_a_value), .compare_p_value(compare_p_value),
        .flag_clear(flag_clear), .flags(flags), .count(count),
        .match_a_pulse(match_a_pulse), .match_p_pulse(match_p_pulse),
        .pin_out(pin_out), .pin_oe(pin_oe));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Off, set fields, then restart so the on-bit edge clears the counter
    task automatic cfg(input logic [1:0] md, input logic [1:0] fn,
                       input logic oc, input logic inv, input logic swp,
                       input logic ccs, input logic [9:0] a,
                       input logic [2:0] p);
        @(negedge clk_sys);
        ctrl.timer_on_bit = 1'b0;
        repeat (4) @(negedge clk_sys);
        {ctrl.mode_select_hi, ctrl.mode_select_lo} = md;
        {ctrl.output_function_hi, ctrl.output_function_lo} = fn;
        ctrl.output_control_bit = oc;
        ctrl.output_invert_bit = inv;
        ctrl.period_duty_swap = swp;
        ctrl.counter_clear_select = ccs;
        compare_a_value = a;
        compare_p_value = p;
        repeat (4) @(negedge clk_sys);
        ctrl.timer_on_bit = 1'b1;
        repeat (6) @(negedge clk_sys);
    endtask

    // One window from a reference pulse up to and including the next one
    task automatic measure(input logic use_a);
        int   n;
        logic prev;
        n = 0;
        m_len = 0; m_hi = 0; m_pa = 0; m_pp = 0; m_tog = 0; m_max = 10'h000;
        do begin
            @(negedge clk_sys);
            n++;
        end while (((use_a ? match_a_pulse : match_p_pulse) !== 1'b1)
                   && n < 2100);
        prev = pin_out;
        do begin
            @(negedge clk_sys);
            m_len++;
            if (pin_out === 1'b1) m_hi++;
            if (pin_out !== prev) m_tog++;
            prev = pin_out;
            if (match_a_pulse === 1'b1) m_pa++;
            if (match_p_pulse === 1'b1) m_pp++;
            if (count > m_max) m_max = count;
        end while (((use_a ? match_a_pulse : match_p_pulse) !== 1'b1)
                   && m_len < 2100);
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            conclude();
        end
    end

    initial begin
        errors = 0; checks_done = 0; cycles = 0;
        rst_b = 1'b0; timer_tick = 1'b1; ctrl = '0;
        compare_a_value = 10'h000; compare_p_value = 3'h0; flag_clear = '0;
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_b = 1'b1;
        for (int i = 0; i < 8; i++) begin
            cfg(CTM_MODE_PWM, t_fn[i][1:0], t_oc[i][0], t_inv[i][0], 1'b0,
                i[0], t_a[i][9:0], t_p[i][2:0]);
            measure(1'b0);
            chk(m_len, (t_p[i] == 0) ? 1024 : t_p[i] * 128);
            chk(m_hi, t_hi[i]);
            chk(m_pp, 1);
            chk(m_pa, (t_a[i] < m_len) ? 1 : 0);
            chk(pin_oe, 1'b1);
        end
        $display("test pwm_table done");
        cfg(CTM_MODE_PWM, CTM_PF_PWM, 1'b1, 1'b0, 1'b1, 1'b0, 10'h12c, 3'h1);
        measure(1'b1);
        chk(m_hi, 128);
        chk(m_pp, 1);
        chk(m_len >= 299 && m_len <= 302, 1);
        $display("test pwm_swap done");
        cfg(CTM_MODE_CMP, CTM_FN_TOG, 1'b0, 1'b0, 1'b0, 1'b1, 10'h12c, 3'h1);
        @(negedge clk_sys);
        flag_clear = 2'b11;
        @(negedge clk_sys);
        flag_clear = 2'b00;
        measure(1'b1);
        chk(m_pp, 0);
        chk(flags.match_p_flag, 1'b0);
        chk(flags.match_a_flag, 1'b1);
        chk(m_tog, 1);
        chk(m_len >= 299 && m_len <= 302, 1);
        $display("test compare_clear_a done");
        cfg(CTM_MODE_CMP, CTM_FN_HIGH, 1'b0, 1'b0, 1'b0, 1'b0, 10'h014, 3'h1);
        measure(1'b0);
        chk(m_len, 128);
        chk(m_pa, 1);
        chk(pin_out, 1'b1);
        ctrl.timer_on_bit = 1'b0;
        repeat (4) @(negedge clk_sys);
        ctrl.timer_on_bit = 1'b1;
        repeat (5) @(negedge clk_sys);
        chk(pin_out, 1'b0);
        $display("test compare_clear_p done");
        cfg(CTM_MODE_CMP, CTM_FN_NONE, 1'b0, 1'b0, 1'b0, 1'b0, 10'h000, 3'h0);
        m_max = 10'h000;
        repeat (1100) begin
            @(negedge clk_sys);
            if (count > m_max) m_max = count;
        end
        chk(m_max, 10'h3ff);
        $display("test overflow done");
        cfg(CTM_MODE_TMR, CTM_FN_HIGH, 1'b1, 1'b0, 1'b0, 1'b0, 10'h014, 3'h1);
        measure(1'b0);
        chk(m_len, 128);
        chk(m_pa, 1);
        chk(pin_oe, 1'b0);
        timer_tick = 1'b0;
        repeat (4) @(negedge clk_sys);
        m_max = count;
        repeat (20) @(negedge clk_sys);
        chk(count, m_max);
        timer_tick = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk(count != m_max, 1'b1);
        $display("test timer_counter done");
        cfg(CTM_MODE_CMP, CTM_FN_LOW, 1'b1, 1'b1, 1'b0, 1'b0, 10'h014, 3'h1);
        chk(pin_out, 1'b0);
        measure(1'b0);
        chk(pin_out, 1'b1);
        $display("test compare_low done");
        conclude();
    end
endmodule // testbench
